//--- core/sac_control.sv
// sac_control: converter control for the 14-bit successive-approximation
// converter: channel rotation, clock divider, sampling phases, bursts,
// calibration, power options, fifo push and threshold event.
// assumes synchronous inputs and a register master that never waits.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ns
module sac_control
  import sac_pkg::*;
(
  input  wire logic          i_core_clk,   // 125 MHz core clock
  input  wire logic          i_reset,      // asynchronous, active high
  input  wire logic [7:0]    i_reg_addr,   // register address
  input  wire logic [7:0]    i_reg_wdata,  // register write data
  input  wire logic          i_reg_wr,     // write strobe
  input  wire logic          i_reg_rd,     // read strobe
  output logic      [7:0]    o_reg_rdata,  // read data, one cycle later
  input  wire sac_seq_in_s   i_seq,        // sequencer status
  input  wire sac_conv_in_s  i_conv,       // converter answers
  output sac_conv_out_s      o_conv,       // converter controls
  output logic               o_fifo_valid, // fifo push strobe
  output logic      [15:0]   o_fifo_data,  // fifo entry
  output logic               o_thresh_evt, // threshold event pulse
  output logic               o_led_off,    // suppress led pulses
  output logic               o_tia_off     // power off tia
);

  // complete state of the block
  typedef struct packed {
    logic [7:0]  limit;      // compare limit
    logic [7:0]  cmpopt;     // compare options
    logic [7:0]  burst;      // burst config
    logic [7:0]  clkpwr;     // clock and power config
    logic [7:0]  timing;     // sampling timing config
    logic [7:0]  sel_lo;     // low channel mask
    logic [7:0]  sel_hi;     // high channel mask
    logic        manual;     // manual mode
    logic        busy;       // conversion or burst running
    logic        cal_run;    // current run is a calibration
    logic        cal_ok;     // calibration data valid
    sac_state_e  st;         // sampling phase
    logic [4:0]  div_cnt;    // converter clock divider
    logic [8:0]  wait_cnt;   // phase length in converter clocks
    logic [5:0]  remain;     // samples left in burst
    logic        first_bst;  // next sequencer burst is the first
    logic        seq_en_q;   // sequencer enable, last cycle
    logic [3:0]  chan;       // selected input
    logic        toggle;     // per-entry toggle bit, flips on every push
    logic        have_first; // first tia result held
    logic [13:0] first_res;  // held first tia result
    logic [13:0] result;     // live converter result
    logic        fifo_v;     // fifo push
    logic [15:0] fifo_d;     // fifo data
    logic        evt;        // threshold pulse
    logic [7:0]  rdata;      // read data
  } sac_regs_s;

  sac_regs_s r_r;   // registered state
  sac_regs_s r_nxt; // next state

  // burst size from the three-bit count field
  function automatic logic [5:0] burst_size(input logic [2:0] n);
    unique case (n)
      3'h0:    burst_size = 6'd2;
      3'h1:    burst_size = 6'd4;
      3'h2:    burst_size = 6'd8;
      3'h3:    burst_size = 6'd16;
      3'h4:    burst_size = 6'd32;
      default: burst_size = 6'd48; // codes 5 and above clamp
    endcase
  endfunction

  // next enabled channel above cur, else lowest enabled
  function automatic logic [3:0] next_chan(input logic [11:0] m, input logic [3:0] cur);
    logic [3:0] lo;
    logic [3:0] hi;
    logic       fh;
    lo = cur;
    hi = cur;
    fh = 1'b0;
    for (int i = NUM_CHAN - 1; i >= 0; i--) begin
      if (m[i]) begin
        lo = 4'(i);
        if (4'(i) > cur) begin
          hi = 4'(i);
          fh = 1'b1;
        end
      end
    end
    next_chan = fh ? hi : lo;
  endfunction

  // lowest enabled channel
  function automatic logic [3:0] low_chan(input logic [11:0] m);
    low_chan = 4'h0;
    for (int i = NUM_CHAN - 1; i >= 0; i--) begin
      if (m[i]) begin
        low_chan = 4'(i);
      end
    end
  endfunction

  logic [11:0] mask;      // combined channel mask
  logic [4:0]  div_last;  // last divider count
  logic        cclk_tick; // one converter clock period passed
  logic [8:0]  settle;    // extra tracking cycles
  logic        man_start; // manual start write
  logic        seq_start; // sequencer trigger taken
  logic        seq_rise;  // sequencer just enabled
  logic [13:0] diff;      // first minus second tia result
  logic        diff_mode; // differential comparison active

  assign mask      = {r_r.sel_hi[3:0], r_r.sel_lo};
  assign div_last  = 5'({r_r.clkpwr[CKP_DIV_LO +: 3], 1'b1});
  assign cclk_tick = (r_r.div_cnt == div_last);
  assign settle    = (r_r.timing[TIM_SET_LO +: 3] == 3'h0) ? 9'd0 :
                     9'(9'd2 << r_r.timing[TIM_SET_LO +: 3]);
  assign man_start = i_reg_wr && (i_reg_addr == ADDR_CTRL) && r_r.manual &&
                     i_reg_wdata[CTL_START] && !r_r.busy && r_r.clkpwr[CKP_EN];
  assign seq_start = i_seq.trigger && !r_r.manual && !r_r.busy && r_r.clkpwr[CKP_EN];
  assign seq_rise  = i_seq.enable && !r_r.seq_en_q;
  assign diff_mode = r_r.cmpopt[CMP_TIA_ONLY] && r_r.cmpopt[CMP_DIFF] && i_seq.tia_pair;
  assign diff      = (r_r.first_res > i_conv.result) ?
                     14'(r_r.first_res - i_conv.result) : 14'h0000;

  // next-state logic
  always_comb begin
    r_nxt        = r_r;
    r_nxt.fifo_v = 1'b0;
    r_nxt.evt    = 1'b0;
    r_nxt.seq_en_q = i_seq.enable;
    // register writes
    if (i_reg_wr) begin
      unique case (i_reg_addr)
        ADDR_LIMIT:  r_nxt.limit  = i_reg_wdata;
        ADDR_CMPOPT: r_nxt.cmpopt = i_reg_wdata;
        ADDR_BURST:  r_nxt.burst  = i_reg_wdata;
        ADDR_CLKPWR: r_nxt.clkpwr = i_reg_wdata;
        ADDR_TIMING: r_nxt.timing = i_reg_wdata;
        ADDR_SEL_LO: begin
          r_nxt.sel_lo = i_reg_wdata;
          if (r_r.manual) begin
            r_nxt.chan = low_chan({r_r.sel_hi[3:0], i_reg_wdata});
          end
        end
        ADDR_SEL_HI: begin
          r_nxt.sel_hi = i_reg_wdata;
          if (r_r.manual) begin
            r_nxt.chan = low_chan({i_reg_wdata[3:0], r_r.sel_lo});
          end
        end
        ADDR_CTRL:   r_nxt.manual = i_reg_wdata[CTL_MANUAL];
        default:     ; // read-only or unmapped: ignored
      endcase
    end
    // sequencer enable edge: full first burst, restart selection
    if (seq_rise) begin
      r_nxt.first_bst = 1'b1;
      r_nxt.chan      = low_chan(mask);
    end
    // divider free-runs, restarted at a new conversion
    r_nxt.div_cnt = cclk_tick ? 5'd0 : 5'(r_r.div_cnt + 5'd1);
    // starting a conversion or burst
    if (man_start || seq_start) begin
      r_nxt.busy       = 1'b1;
      r_nxt.div_cnt    = 5'd0;
      r_nxt.cal_run    = man_start && r_r.clkpwr[CKP_CAL];
      r_nxt.have_first = seq_start ? 1'b0 : r_r.have_first;
      if (!r_r.burst[BST_MULTI]) begin
        r_nxt.remain = 6'd1;
      // a trigger in the very cycle of the enable edge still gets the full burst
      end else if (seq_start && !r_r.first_bst && !seq_rise) begin
        r_nxt.remain = 6'(burst_size(r_r.burst[BST_N_LO +: 3]) - 6'd1);
      end else begin
        r_nxt.remain = burst_size(r_r.burst[BST_N_LO +: 3]);
      end
      if (seq_start) begin
        r_nxt.first_bst = 1'b0;
      end
      r_nxt.st       = r_r.timing[TIM_DISCH] ? SAC_DISCH : SAC_TRACK;
      r_nxt.wait_cnt = r_r.timing[TIM_DISCH] ? 9'd0 : settle;
    end
    // sampling phases
    unique case (r_r.st)
      SAC_IDLE: ;
      SAC_DISCH: begin
        // one converter clock of discharge, then tracking
        if (cclk_tick) begin
          r_nxt.st       = SAC_TRACK;
          r_nxt.wait_cnt = settle;
        end
      end
      SAC_TRACK: begin
        // one base tracking clock plus the settling extension
        if (cclk_tick) begin
          if (r_r.wait_cnt == 9'd0) begin
            r_nxt.st = SAC_CONV;
          end else begin
            r_nxt.wait_cnt = 9'(r_r.wait_cnt - 9'd1);
          end
        end
      end
      SAC_CONV: begin
        // wait for the core to finish
        if (i_conv.done) begin
          r_nxt.result = i_conv.result;
          if (r_r.cal_run) begin
            r_nxt.cal_ok  = 1'b1;
            r_nxt.remain  = 6'd0; // no burst count left behind
            r_nxt.cal_run = 1'b0;
            r_nxt.busy    = 1'b0;
            r_nxt.st      = SAC_IDLE;
          end else begin
            r_nxt.fifo_v = 1'b1;
            r_nxt.fifo_d = {i_conv.result, 1'b0, ~r_r.toggle};
            r_nxt.toggle = ~r_r.toggle;
            r_nxt.chan   = next_chan(mask, r_r.chan);
            // threshold check
            if (diff_mode) begin
              if (r_r.chan == CHAN_TIA) begin
                if (!r_r.have_first) begin
                  r_nxt.have_first = 1'b1;
                  r_nxt.first_res  = i_conv.result;
                end else begin
                  r_nxt.have_first = 1'b0;
                  r_nxt.evt = diff[13:CMP_LSB] > r_r.limit;
                end
              end
            end else if (!r_r.cmpopt[CMP_TIA_ONLY] || r_r.chan == CHAN_TIA) begin
              r_nxt.evt = i_conv.result[13:CMP_LSB] > r_r.limit;
            end
            if (r_r.remain <= 6'd1) begin
              r_nxt.busy   = 1'b0;
              r_nxt.remain = 6'd0;
              r_nxt.st     = SAC_IDLE;
            end else begin
              r_nxt.remain   = 6'(r_r.remain - 6'd1);
              r_nxt.div_cnt  = 5'd0;
              r_nxt.st       = r_r.timing[TIM_DISCH] ? SAC_DISCH : SAC_TRACK;
              r_nxt.wait_cnt = r_r.timing[TIM_DISCH] ? 9'd0 : settle;
            end
          end
        end
      end
      default: r_nxt.st = SAC_IDLE; // illegal code recovers
    endcase
    // converter disabled: abort and drop calibration
    if (!r_r.clkpwr[CKP_EN]) begin
      r_nxt.cal_ok  = 1'b0;
      r_nxt.cal_run = 1'b0;
      r_nxt.busy    = 1'b0;
      r_nxt.st      = SAC_IDLE;
      r_nxt.remain  = 6'd0;
    end
    // read data, valid the cycle after the strobe
    r_nxt.rdata = 8'h00;
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        ADDR_LIMIT:  r_nxt.rdata = r_r.limit;
        ADDR_CMPOPT: r_nxt.rdata = r_r.cmpopt;
        ADDR_BURST:  r_nxt.rdata = r_r.burst;
        ADDR_CLKPWR: r_nxt.rdata = r_r.clkpwr;
        ADDR_TIMING: r_nxt.rdata = r_r.timing;
        ADDR_SEL_LO: r_nxt.rdata = r_r.sel_lo;
        ADDR_SEL_HI: r_nxt.rdata = r_r.sel_hi;
        ADDR_RES_LO: r_nxt.rdata = r_r.result[7:0];
        ADDR_RES_HI: r_nxt.rdata = {2'b00, r_r.result[13:8]};
        ADDR_CTRL:   r_nxt.rdata = {5'h00, r_r.cal_ok,
                                    r_r.busy && r_r.manual, r_r.manual};
        default:     r_nxt.rdata = 8'h00; // unmapped reads zero
      endcase
    end
  end

  // state register
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      r_r        <= '0;
      r_r.limit  <= RST_LIMIT;
      r_r.cmpopt <= RST_ZERO;
      r_r.st     <= SAC_IDLE;
    end else begin
      r_r <= r_nxt;
    end
  end

  // converter and front-end controls
  always_comb begin
    o_conv           = '0;
    // start, discharge and tracking are masked while the converter is held in reset
    o_conv.start     = (r_r.st == SAC_TRACK) && cclk_tick && (r_r.wait_cnt == 9'd0) &&
                       r_r.clkpwr[CKP_EN];
    o_conv.cal       = r_r.cal_run;
    o_conv.reset     = !r_r.clkpwr[CKP_EN];
    o_conv.powerdown = r_r.timing[TIM_SELFPD] && (r_r.st == SAC_IDLE);
    o_conv.discharge = (r_r.st == SAC_DISCH) && r_r.clkpwr[CKP_EN];
    o_conv.track     = (r_r.st == SAC_TRACK) && r_r.clkpwr[CKP_EN];
    o_conv.clk       = (r_r.div_cnt <= 5'({1'b0, r_r.clkpwr[CKP_DIV_LO +: 3]}));
    o_conv.sel       = 12'(12'h001 << r_r.chan);
  end

  // ultra-low-power gating outside the tia sequence
  assign o_led_off = r_r.clkpwr[CKP_ULP] && (i_seq.sub_count != 4'h0) &&
                     !i_seq.tia_sequence;
  assign o_tia_off = o_led_off;

  assign o_reg_rdata  = r_r.rdata;
  assign o_fifo_valid = r_r.fifo_v;
  assign o_fifo_data  = r_r.fifo_d;
  assign o_thresh_evt = r_r.evt;

endmodule // sac_control

//--- core/sac_pkg.sv
// sac_pkg: register map, field positions, reset values, states and
// carrier structs for the converter control block.
// assumes an 8-bit register port and a 125 MHz core clock.
package sac_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_LIMIT   = 8'h68; // conversion_compare_limit
  localparam logic [7:0] ADDR_CMPOPT  = 8'h69; // compare_options
  localparam logic [7:0] ADDR_BURST   = 8'h88; // burst_config
  localparam logic [7:0] ADDR_CLKPWR  = 8'h89; // converter_clock_power_config
  localparam logic [7:0] ADDR_TIMING  = 8'h8A; // sampling_timing_config
  localparam logic [7:0] ADDR_SEL_LO  = 8'h8B; // input_select_low
  localparam logic [7:0] ADDR_SEL_HI  = 8'h8C; // input_select_high
  localparam logic [7:0] ADDR_RES_LO  = 8'h8E; // raw_result_low
  localparam logic [7:0] ADDR_RES_HI  = 8'h8F; // raw_result_high
  localparam logic [7:0] ADDR_CTRL    = 8'h90; // manual_control
  // reset values
  localparam logic [7:0] RST_LIMIT    = 8'hFF;
  localparam logic [7:0] RST_ZERO     = 8'h00;
  // field positions
  localparam int CMP_TIA_ONLY = 0;
  localparam int CMP_DIFF     = 1;
  localparam int BST_MULTI    = 0;
  localparam int BST_N_LO     = 1;
  localparam int CKP_EN       = 0;
  localparam int CKP_ULP      = 1;
  localparam int CKP_CAL      = 2;
  localparam int CKP_DIV_LO   = 3;
  localparam int TIM_SET_LO   = 0;
  localparam int TIM_DISCH    = 3;
  localparam int TIM_SELFPD   = 4;
  localparam int CTL_MANUAL   = 0;
  localparam int CTL_START    = 1;
  localparam int CTL_CAL_OK   = 2;
  // comparison window, channel count and tia channel
  localparam int CMP_LSB      = 6;
  localparam int NUM_CHAN     = 12;
  localparam logic [3:0] CHAN_TIA = 4'h0;
  // sampling phase states
  typedef enum logic [3:0] {
    SAC_IDLE  = 4'b0001,
    SAC_DISCH = 4'b0010,
    SAC_TRACK = 4'b0100,
    SAC_CONV  = 4'b1000
  } sac_state_e;
  // outputs toward the multiplexer and converter core
  typedef struct packed {
    logic        start;
    logic        cal;
    logic        reset;
    logic        powerdown;
    logic        discharge;
    logic        track;
    logic        clk;
    logic [11:0] sel;
  } sac_conv_out_s;
  // answers from the converter core
  typedef struct packed {
    logic        done;
    logic [13:0] result;
  } sac_conv_in_s;
  // sequencer status and trigger
  typedef struct packed {
    logic       enable;
    logic       trigger;
    logic       tia_pair;
    logic       tia_sequence;
    logic [3:0] sub_count;
  } sac_seq_in_s;
endpackage

//--- sim/sac_control_properties.sv
// sac_control_properties: port checks on the converter control block.
// assumes it is bound to every sac_control instance.
`timescale 1ns/1ns
module sac_control_checker
  import sac_pkg::*;
(
  input wire logic          i_core_clk,
  input wire logic          i_reset,
  input wire logic [7:0]    i_reg_addr,
  input wire logic [7:0]    i_reg_wdata,
  input wire logic          i_reg_wr,
  input wire logic          i_reg_rd,
  input wire logic [7:0]    o_reg_rdata,
  input wire sac_seq_in_s   i_seq,
  input wire sac_conv_in_s  i_conv,
  input wire sac_conv_out_s o_conv,
  input wire logic          o_fifo_valid,
  input wire logic [15:0]   o_fifo_data,
  input wire logic          o_thresh_evt,
  input wire logic          o_led_off,
  input wire logic          o_tia_off
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  logic tog_r;  // toggle bit of the last entry
  logic seen_r; // an entry was pushed since reset
  // remember the toggle bit of each pushed entry
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      tog_r <= 1'b0;
      seen_r <= 1'b0;
    end else if (o_fifo_valid) begin
      tog_r <= o_fifo_data[0];
      seen_r <= 1'b1;
    end
  end
  property p_rdata_idle;
    !$past(i_reg_rd) |-> o_reg_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside a read");
  property p_evt_push;
    o_thresh_evt |-> o_fifo_valid ##1 !o_thresh_evt;
  endproperty
  a_evt_push: assert property (p_evt_push)
    else $error("event not a single pulse with a result");
  property p_push_data;
    o_fifo_valid |-> $past(i_conv.done) && o_fifo_data[15:1] == {$past(i_conv.result), 1'b0};
  endproperty
  a_push_data: assert property (p_push_data)
    else $error("fifo entry not result times four");
  property p_toggle;
    o_fifo_valid && seen_r |-> o_fifo_data[0] != tog_r;
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("fifo toggle bit did not toggle");
  property p_quiet_reset;
    o_conv.reset |-> !o_conv.start && !o_conv.track;
  endproperty
  a_quiet_reset: assert property (p_quiet_reset)
    else $error("converter active while held in reset");
  property p_ulp;
    o_led_off || o_tia_off |-> i_seq.sub_count != 4'h0 && !i_seq.tia_sequence;
  endproperty
  a_ulp: assert property (p_ulp)
    else $error("led or tia off outside the allowed case");
  property p_sel_move;
    !$stable(o_conv.sel) |-> $past(i_conv.done || i_reg_wr || i_seq.enable);
  endproperty
  a_sel_move: assert property (p_sel_move)
    else $error("channel changed without a cause");
  property p_start_pulse;
    o_conv.start |-> o_conv.track ##1 !o_conv.start;
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("start not a one cycle pulse in tracking");
endmodule // sac_control_checker
bind sac_control sac_control_checker sac_control_checker_inst (.i_core_clk, .i_reset,
  .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .i_seq, .i_conv, .o_conv,
  .o_fifo_valid, .o_fifo_data, .o_thresh_evt, .o_led_off, .o_tia_off);

//--- sim/sac_conv_model.sv
// sac_conv_model: behavioural converter core behind the input multiplexer.
// assumes the control block raises start for one cycle per conversion.
`timescale 1ns/1ns
module sac_conv_model
  import sac_pkg::*;
(
  input  wire logic          i_core_clk, // core clock
  input  wire sac_conv_out_s i_ctl,      // controls from the block
  input  wire logic [13:0]   i_value,    // result of the next answer
  input  wire logic [3:0]    i_lat,      // answer delay in cycles
  output sac_conv_in_s       o_ans       // done pulse and result
);
  int          cnt    = 0;        // cycles left until the answer
  logic [13:0] last_v = 14'h0000; // last result handed out
  // one answer per start; the result lines never hold a stale value
  always @(posedge i_core_clk) begin
    o_ans.done <= 1'b0;
    o_ans.result <= ~last_v;
    if (i_ctl.reset) begin
      cnt <= 0;
    end else if (i_ctl.start) begin
      cnt <= i_lat + 1;
    end else if (cnt == 1) begin
      o_ans.done <= 1'b1;
      o_ans.result <= i_value;
      last_v <= i_value;
      cnt <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule // sac_conv_model

//--- sim/testbench.sv
// testbench: self-checking bench for sac_control beside a converter model.
// assumes the model answers each start pulse lat plus one cycles later.
`timescale 1ns/1ns
module testbench;
  import sac_pkg::*;
  logic          clk, rst, wr, rd, fvalid, evt, led_off, tia_off; // bus and flags
  logic [7:0]    addr, wdata, rdata, v, lim;  // bus, scratch, limit in force
  logic [13:0]   cur_val;                     // result the model returns
  logic [3:0]    lat;                         // model answer delay
  logic [15:0]   seed, fdata;                 // lfsr state, fifo entry
  logic          tia_only, diff_on;           // compare options in force
  sac_seq_in_s   seq;                         // sequencer inputs
  sac_conv_in_s  ans;                         // converter answers
  sac_conv_out_s ctl;                         // converter controls
  int            fail_count, n_tests, n_push, ptr, base;
  int            chans[$];                    // enabled channels, low first
  int            stab[8] = '{0, 4, 8, 16, 32, 64, 128, 256};
  int            bsz[6] = '{2, 4, 8, 16, 32, 48};
  logic [7:0]    rst_a[10] = '{8'h68, 8'h69, 8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8E, 8'h8F,
                               8'h70};
  logic [7:0]    lims[3] = '{8'h80, 8'hFF, 8'h3F};
  sac_control sac_control_inst (.i_core_clk(clk), .i_reset(rst), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_seq(seq),
    .i_conv(ans), .o_conv(ctl), .o_fifo_valid(fvalid), .o_fifo_data(fdata),
    .o_thresh_evt(evt), .o_led_off(led_off), .o_tia_off(tia_off));
  sac_conv_model sac_conv_model_inst (.i_core_clk(clk), .i_ctl(ctl), .i_value(cur_val),
    .i_lat(lat), .o_ans(ans));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic wait_push(input int target);
    for (int k = 0; k < 5000 && n_push < target; k++) @(negedge clk);
    repeat (40) @(negedge clk);
  endtask
  // one manual conversion, timing of clock, discharge and tracking measured
  task automatic conv(input int d, input int st, input int dis);
    int k, r0, r1, nt, nd, np;
    logic pc;
    cur_val <= seed[13:0];
    lat <= {1'b0, seed[2:0]};
    seed = lfsr(seed);
    wr_reg(ADDR_CLKPWR, {2'b00, d[2:0], 3'b001});
    wr_reg(ADDR_TIMING, {3'b000, dis[1:0], st[2:0]});
    base = n_push;
    k = 0;
    r0 = -1;
    r1 = -1;
    nt = 0;
    nd = 0;
    np = 0;
    pc = ctl.clk;
    wr_reg(ADDR_CTRL, 8'h03);
    while (n_push == base && k < 9000) begin
      @(negedge clk);
      k++;
      nt += ctl.track;
      np += ctl.track && ctl.powerdown;
      nd += ctl.discharge;
      if (ctl.clk && !pc && r0 < 0) r0 = k;
      else if (ctl.clk && !pc && r1 < 0) r1 = k;
      pc = ctl.clk;
    end
    check(r1 - r0, 2 * (d + 1));
    check(nt, (1 + stab[st]) * 2 * (d + 1));
    check(nd, dis[0] ? 2 * (d + 1) : 0);
    check(np, 0);
    check(ctl.powerdown, dis[1]);
  endtask
  // every push compared with the bench model of value, event and channel
  always @(negedge clk) begin
    if (fvalid === 1'b1) begin
      check(fdata[15:1], {cur_val, 1'b0});
      check(evt, (cur_val[13:6] > lim) && (!tia_only || chans[ptr] == 0) &&
                 !diff_on); // equal results in a pair differ by zero
      ptr = (ptr + 1) % chans.size();
      check(ctl.sel, 12'h001 << chans[ptr]);
      n_push++;
    end
  end
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    give_verdict();
  end
  initial begin
    {rst, addr, wdata, wr, rd, seq, cur_val, lat} = '0;
    rst = 1'b1;
    {fail_count, n_tests, n_push, ptr} = '0;
    {lim, tia_only, diff_on, seed} = {8'hFF, 1'b0, 1'b0, 16'h5258};
    chans = '{0, 2, 5, 11};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    foreach (rst_a[i]) begin
      rd_reg(rst_a[i], v);
      check(v, i == 0 ? 8'hFF : 8'h00);
    end
    for (int i = 0; i < 6; i++) begin
      wr_reg(rst_a[i == 3 ? 6 : i], seed[7:0]);
      rd_reg(rst_a[i == 3 ? 6 : i], v);
      check(v, seed[7:0]);
      seed = lfsr(seed);
    end
    wr_reg(ADDR_RES_LO, 8'hA5);
    rd_reg(ADDR_RES_LO, v);
    check(v, 8'h00);
    $display("test registers done");
    wr_reg(ADDR_LIMIT, 8'hFF);
    wr_reg(ADDR_CMPOPT, 8'h00);
    wr_reg(ADDR_BURST, 8'h00);
    wr_reg(ADDR_CLKPWR, 8'h01);
    wr_reg(ADDR_CTRL, 8'h01);
    wr_reg(ADDR_SEL_LO, 8'h25);
    // pin 2 input on channel 11: pad setup first
    wr_reg(8'hC6, 8'h47);
    wr_reg(8'hC2, 8'h0C);
    wr_reg(8'hC3, 8'h0C);
    wr_reg(ADDR_SEL_HI, 8'h08);
    ptr = 0;
    for (int i = 0; i < 8; i++) conv(i, (i + 1) % 8, i);
    $display("test timing done");
    for (int c = 0; c < 3; c++) begin
      lim = lims[c];
      tia_only = (c == 2);
      wr_reg(ADDR_LIMIT, lim);
      wr_reg(ADDR_CMPOPT, {7'h00, tia_only});
      repeat (4) conv(0, 1, 0);
    end
    $display("test threshold done");
    for (int n = 0; n < 6; n++) begin
      wr_reg(ADDR_BURST, {4'h0, n[2:0], 1'b1});
      base = n_push;
      wr_reg(ADDR_CTRL, 8'h03);
      rd_reg(ADDR_CTRL, v);
      check(v[1], 1'b1);
      wait_push(base + bsz[n]);
      check(n_push - base, bsz[n]);
    end
    rd_reg(ADDR_CTRL, v);
    check(v[1], 1'b0);
    $display("test bursts done");
    wr_reg(ADDR_CTRL, 8'h00);
    wr_reg(ADDR_BURST, 8'h05);
    @(posedge clk);
    seq.enable <= 1'b1;
    ptr = 0;
    repeat (2) @(negedge clk);
    check(ctl.sel, 12'h001);
    for (int k = 0; k < 3; k++) begin
      // third burst: differential compare over equal results, never an event
      if (k == 2) begin
        seq.tia_pair <= 1'b1;
        diff_on = 1'b1;
        wr_reg(ADDR_CMPOPT, 8'h03);
      end
      base = n_push;
      @(posedge clk);
      seq.trigger <= 1'b1;
      @(posedge clk);
      seq.trigger <= 1'b0;
      wait_push(base + (k == 0 ? 8 : 7));
      check(n_push - base, k == 0 ? 8 : 7);
    end
    wr_reg(ADDR_CLKPWR, 8'h03);
    repeat (6) begin
      @(posedge clk);
      seq.sub_count <= seed[3:0];
      seq.tia_sequence <= seed[4];
      seed = lfsr(seed);
      @(negedge clk);
      check({led_off, tia_off}, {2{seq.sub_count != 4'h0 && !seq.tia_sequence}});
    end
    $display("test sequencer done");
    seq.enable <= 1'b0;
    wr_reg(ADDR_CTRL, 8'h01);
    wr_reg(ADDR_CLKPWR, 8'h05);
    base = n_push;
    wr_reg(ADDR_CTRL, 8'h03);
    @(negedge clk);
    check(ctl.cal, 1'b1);
    repeat (60) @(negedge clk);
    rd_reg(ADDR_CTRL, v);
    check(v[2], 1'b1);
    check(n_push, base);
    check(ctl.cal, 1'b0);
    wr_reg(ADDR_CLKPWR, 8'h04);
    rd_reg(ADDR_CTRL, v);
    check(v[2], 1'b0);
    check(ctl.reset, 1'b1);
    $display("test calibration done");
    give_verdict();
  end
endmodule // testbench
